// *** hw/terl_event_logic.v ***
// Functional notes
// - Match request asserted while match flag set and its enable is 1.
// - Match request drops as soon as the match flag is cleared.
// - Overflow request asserted while overflow flag set and enabled.
// - Overflow request drops once the overflow flag clears.
// - Underflow request asserted while underflow flag set and enabled.
// - Underflow request drops once the underflow flag clears.
// - Sixteen match sources per unit: four on channels 0,3, two elsewhere.
// - One overflow source on every channel.
// - Underflow sources only on channels 1,2,4,5.
// - Only the A match of each channel can trigger DMA.
// - The A match flag set with conversion enable 1 requests A/D conversion start.
// - Only unit 0 channels drive conversion start requests.
// - Compare match fires at the count update while counter equals register.
// - Compare match drives output pin to configured level.
// - No further compare match until the counter's next input clock.
// - Second unit channels form channels 6 to 11 with same flags.
// - Variant: channels 4 and 5 lack capture; A/B from compare only.
// - Fixed source order within a channel; controller reorders channels.
// - DMA start clears the A flag and request automatically.
`timescale 1ns/1ps
`include "terl_consts.vh"

module terl_event_logic #(
  parameter NO_CAPTURE_45 = 0
) (
  input  wire         ref_clk,
  input  wire         reset,
  input  wire         wb_cyc_i,
  input  wire         wb_stb_i,
  input  wire         wb_we_i,
  input  wire [8:0]   wb_adr_i,
  input  wire [3:0]   wb_sel_i,
  input  wire [31:0]  wb_dat_i,
  output reg  [31:0]  wb_dat_o,
  output wire         wb_ack_o,
  input  wire [191:0] timer_counter,
  input  wire [11:0]  count_tick,
  input  wire [11:0]  overflow_evt,
  input  wire [11:0]  underflow_evt,
  input  wire [47:0]  capture_evt,
  input  wire [11:0]  dma_start,
  output wire [47:0]  match_irq_request,
  output wire [11:0]  overflow_irq_request,
  output wire [11:0]  underflow_irq_request,
  output wire [11:0]  dma_request,
  output wire [5:0]   conversion_start_request,
  output wire [47:0]  compare_output_pin
);

  reg          ack_q;
  wire         acc;
  wire         a_unit;
  wire [2:0]   a_chl;
  wire [3:0]   a_idx;
  wire [2:0]   a_reg;
  wire         a_ok;
  wire         wr;
  wire         rd;
  wire [71:0]  stat_all;
  wire [95:0]  en_all;
  wire [143:0] ioc_all;
  wire [767:0] mr_all;

  assign acc    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign a_unit = wb_adr_i[`TERL_A_UNIT];
  assign a_chl  = wb_adr_i[`TERL_A_CH_HI:`TERL_A_CH_LO];
  assign a_reg  = wb_adr_i[`TERL_A_REG_HI:`TERL_A_REG_LO];
  assign a_ok   = (a_chl < 3'h6);
  assign a_idx  = a_unit ? ({1'b0, a_chl} + 4'h6) : {1'b0, a_chl};
  assign wr     = acc & wb_we_i & a_ok;
  assign rd     = acc & ~wb_we_i & a_ok;
  assign wb_ack_o = ack_q;

  // One-wait-state classic slave; unmapped reads return zero
  always @(posedge ref_clk) begin
    if (reset) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_q <= acc;
      if (acc) begin
        wb_dat_o <= 32'h00000000;
        if (rd) begin
          case (a_reg)
            `TERL_R_STAT:
              wb_dat_o[`TERL_SW-1:0] <= stat_all[a_idx*`TERL_SW +: `TERL_SW];
            `TERL_R_EN:
              wb_dat_o[`TERL_EW-1:0] <= en_all[a_idx*`TERL_EW +: `TERL_EW];
            `TERL_R_IOC:
              wb_dat_o[`TERL_IOW-1:0] <=
                ioc_all[a_idx*`TERL_IOW +: `TERL_IOW];
            `TERL_R_MRA, `TERL_R_MRB, `TERL_R_MRC, `TERL_R_MRD:
              wb_dat_o[`TERL_CW-1:0] <=
                mr_all[({a_idx, a_reg[1:0]})*`TERL_CW +: `TERL_CW];
            default:
              wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  genvar c;
  genvar s;
  generate
    for (c = 0; c < `TERL_NCH; c = c + 1) begin : g_ch
      localparam integer CI = c;
      localparam integer LC = c % `TERL_NCH_UNIT;
      localparam HAS_CD  = (LC == 0) || (LC == 3);
      localparam HAS_UNF = !HAS_CD;
      localparam CAP_OK  = !(NO_CAPTURE_45 && (LC == 4 || LC == 5));
      localparam [3:0] SLOT_MASK = HAS_CD ? 4'hF : 4'h3;

      reg  [`TERL_SW-1:0]  stat_q;
      reg  [`TERL_SW-1:0]  stat_d;
      reg  [`TERL_SW-1:0]  arm_q;
      reg  [`TERL_EW-1:0]  en_q;
      reg  [`TERL_IOW-1:0] ioc_q;
      wire [3:0]           ma_evt;
      wire [`TERL_SW-1:0]  set_v;
      wire [`TERL_SW-1:0]  clr_v;
      wire                 me;
      wire [`TERL_CW-1:0]  cnt;

      assign me  = (a_idx == CI[3:0]);
      assign cnt = timer_counter[c*`TERL_CW +: `TERL_CW];

      for (s = 0; s < `TERL_NSLOT; s = s + 1) begin : g_slot
        localparam integer RI = `TERL_R_MRA + s;
        localparam EXIST = SLOT_MASK[s];
        reg  [`TERL_CW-1:0] mr_q;
        reg                 pin_q;
        wire cap_mode;
        wire mr_wr;
        wire cmp_hit;
        wire cap_hit;

        assign cap_mode = CAP_OK & ioc_q[`TERL_IO_CAP + s];
        assign mr_wr    = wr & me & (a_reg == RI[2:0]) &
                          (wb_sel_i[1:0] != 2'h0);
        // Match on the update tick; a same-cycle register write wins
        assign cmp_hit  = EXIST & ~cap_mode & count_tick[c] &
                          (cnt == mr_q) & ~mr_wr;
        assign cap_hit  = EXIST & cap_mode & capture_evt[c*4 + s];
        assign ma_evt[s] = cmp_hit | cap_hit;
        assign mr_all[(c*4+s)*`TERL_CW +: `TERL_CW] =
          EXIST ? mr_q : 16'h0000;

        always @(posedge ref_clk) begin
          if (reset) begin
            mr_q <= `TERL_RST_MR;
          end else if (cap_hit) begin
            mr_q <= cnt;
          end else if (mr_wr) begin
            if (wb_sel_i[0])
              mr_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              mr_q[15:8] <= wb_dat_i[15:8];
          end
        end

        always @(posedge ref_clk) begin
          if (reset) begin
            pin_q <= 1'b0;
          end else if (cmp_hit) begin
            case (ioc_q[2*s +: 2])
              `TERL_IO_LOW:    pin_q <= 1'b0;
              `TERL_IO_HIGH:   pin_q <= 1'b1;
              `TERL_IO_TOGGLE: pin_q <= ~pin_q;
              default:         pin_q <= pin_q;
            endcase
          end
        end

        assign match_irq_request[c*4 + s] =
          stat_q[s] & en_q[s];
        assign compare_output_pin[c*4 + s] = pin_q;
      end

      // Flags set regardless of enables; source set beats any clear
      assign set_v = {underflow_evt[c] & HAS_UNF, overflow_evt[c],
                      ma_evt & SLOT_MASK};
      assign clr_v = ({`TERL_SW{wr & me & (a_reg == `TERL_R_STAT) &
                       wb_sel_i[0]}} & arm_q &
                      ~wb_dat_i[`TERL_SW-1:0]) |
                     {{(`TERL_SW-1){1'b0}}, dma_start[c]};

      always @* begin
        stat_d = set_v | (stat_q & ~clr_v);
      end

      always @(posedge ref_clk) begin
        if (reset) begin
          stat_q <= `TERL_RST_STAT;
          arm_q  <= `TERL_RST_STAT;
          en_q   <= `TERL_RST_EN;
          ioc_q  <= `TERL_RST_IOC;
        end else begin
          stat_q <= stat_d;
          if (rd & me & (a_reg == `TERL_R_STAT))
            arm_q <= stat_q;
          else
            arm_q <= arm_q & stat_d;
          if (wr & me & (a_reg == `TERL_R_EN) & wb_sel_i[0])
            en_q <= wb_dat_i[`TERL_EW-1:0] &
                    {1'b1, 1'b0, HAS_UNF[0], 1'b1, SLOT_MASK};
          if (wr & me & (a_reg == `TERL_R_IOC)) begin
            if (wb_sel_i[0])
              ioc_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              ioc_q[11:8] <= wb_dat_i[11:8] & SLOT_MASK;
          end
        end
      end

      assign stat_all[c*`TERL_SW +: `TERL_SW]   = stat_q;
      assign en_all[c*`TERL_EW +: `TERL_EW]     = en_q;
      assign ioc_all[c*`TERL_IOW +: `TERL_IOW]  = ioc_q;

      assign overflow_irq_request[c] =
        stat_q[`TERL_B_OVF] & en_q[`TERL_B_OVF];
      assign underflow_irq_request[c] =
        stat_q[`TERL_B_UNF] & en_q[`TERL_B_UNF];
      // DMA from the A match only, cleared through dma_start
      assign dma_request[c] =
        stat_q[`TERL_B_MA] & en_q[`TERL_B_MA];
      if (c < `TERL_NCH_UNIT) begin : g_conv
        // Converter side decides whether to act on it
        assign conversion_start_request[c] =
          stat_q[`TERL_B_MA] & en_q[`TERL_B_CONV];
      end
    end
  endgenerate

endmodule // terl_event_logic

// *** hw/terl_consts.vh ***
`ifndef TERL_CONSTS_VH
`define TERL_CONSTS_VH

// Channel counts, slots per channel and counter width
`define TERL_NCH        12
`define TERL_NCH_UNIT   6
`define TERL_NSLOT      4
`define TERL_CW         16

// Wishbone address fields (byte address)
`define TERL_AW         9
`define TERL_A_UNIT     8
`define TERL_A_CH_HI    7
`define TERL_A_CH_LO    5
`define TERL_A_REG_HI   4
`define TERL_A_REG_LO   2

// Register index within a channel (byte offset = index * 4)
`define TERL_R_STAT     3'h0
`define TERL_R_EN       3'h1
`define TERL_R_IOC      3'h2
`define TERL_R_MRA      3'h4
`define TERL_R_MRB      3'h5
`define TERL_R_MRC      3'h6
`define TERL_R_MRD      3'h7

// Status / enable bit positions and register widths
`define TERL_B_MA       0
`define TERL_B_OVF      4
`define TERL_B_UNF      5
`define TERL_B_CONV     7
`define TERL_SW         6
`define TERL_EW         8

// I/O control: two level bits per slot, capture-mode bit per slot
`define TERL_IOW        12
`define TERL_IO_CAP     8
`define TERL_IO_NONE    2'h0
`define TERL_IO_LOW     2'h1
`define TERL_IO_HIGH    2'h2
`define TERL_IO_TOGGLE  2'h3

// Reset values
`define TERL_RST_STAT   6'h00
`define TERL_RST_EN     8'h00
`define TERL_RST_IOC    12'h000
`define TERL_RST_MR     16'hFFFF
`define TERL_RST_PIN    4'h0

`endif

// *** verif/terl_checker.sv ***
`timescale 1ns/1ps
module terl_checker (
  input wire        ref_clk,
  input wire        reset,
  input wire        wb_cyc_i,
  input wire        wb_we_i,
  input wire [11:0] count_tick,
  input wire [11:0] overflow_evt,
  input wire [47:0] capture_evt,
  input wire [11:0] dma_start,
  input wire [47:0] match_irq_request,
  input wire [11:0] overflow_irq_request,
  input wire [11:0] underflow_irq_request,
  input wire [11:0] dma_request,
  input wire [47:0] compare_output_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire        wr = wb_cyc_i && wb_we_i;
  wire [11:0] a_req;
  for (genvar c = 0; c < 12; c++) assign a_req[c] = match_irq_request[4*c];
  a_dma_a_only: assert property (dma_request == a_req)
    else $error("dma not A match");
  a_no_cd_src: assert property (!(match_irq_request & 48'hCC0CC0CC0CC0))
    else $error("absent match source");
  a_no_unf_src: assert property (!(underflow_irq_request & 12'h249))
    else $error("absent underflow source");
  a_ovf_rise: assert property ($rose(overflow_irq_request[5])
    |-> $past(overflow_evt[5]) || $past(wr)) else $error("ovf rise");
  a_ovf_fall: assert property ($fell(overflow_irq_request[5])
    |-> $past(wr) || $past(reset)) else $error("ovf fall");
  a_match_fall: assert property ($fell(match_irq_request[36])
    |-> $past(wr) || $past(dma_start[9]) || $past(reset))
    else $error("match fall");
  a_dma_clear: assert property (dma_start[9] && !capture_evt[36]
    && !count_tick[9] |=> !dma_request[9]) else $error("dma kept");
  a_pin_tick: assert property ($changed(compare_output_pin[0])
    |-> $past(count_tick[0]) || $past(reset)) else $error("pin off tick");
endmodule // terl_checker
bind terl_event_logic terl_checker i_terl_checker (.ref_clk, .reset,
  .wb_cyc_i, .wb_we_i, .count_tick, .overflow_evt, .capture_evt, .dma_start,
  .match_irq_request, .overflow_irq_request, .underflow_irq_request,
  .dma_request, .compare_output_pin);

// *** verif/terl_partner.sv ***
`timescale 1ns/1ps
module terl_partner (
  input wire          ref_clk,
  input wire          reset,
  input wire          dma_on,
  input wire [1:0]    dly,
  input wire          adc_sel,
  input wire [11:0]   dma_request,
  input wire [5:0]    conversion_start_request,
  output logic [11:0] dma_start = 12'h000,
  output int          n_conv
);
  logic [1:0] wait_q [12];
  logic       cs_q;
  always @(posedge ref_clk) begin
    cs_q <= |conversion_start_request;
    if (reset) n_conv <= 0;
    else if (adc_sel && !cs_q && |conversion_start_request)
      n_conv <= n_conv + 1;
    for (int c = 0; c < 12; c++) begin
      dma_start[c] <= 1'b0;
      if (reset || !dma_on || !dma_request[c] || dma_start[c])
        wait_q[c] <= 2'h0;
      else if (wait_q[c] == dly) dma_start[c] <= 1'b1;
      else wait_q[c] <= wait_q[c] + 2'h1;
    end
  end
endmodule // terl_partner

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic         ref_clk = 1'b0, reset = 1'b1, dma_on = 1'b0, g;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [8:0]   wb_adr_i = 9'h000;
  logic [3:0]   wb_sel_i = 4'hF;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q;
  logic [191:0] timer_counter = 192'h0;
  logic [11:0]  count_tick = 12'h0, overflow_evt = 12'h0;
  logic [11:0]  underflow_evt = 12'h0, dma_start, dma_request;
  logic [11:0]  overflow_irq_request, underflow_irq_request;
  logic [47:0]  capture_evt = 48'h0, match_irq_request, compare_output_pin;
  logic [5:0]   conversion_start_request;
  logic [1:0]   dly = 2'h3;
  int           mismatches = 0, n_checks = 0, ncyc = 0, n_conv, c, k;
  // Channel, kind (A-D, ovf, unf), enable, flag, request
  logic [23:0]  rows [12] = '{24'h000111, 24'h030811, 24'h010410,
    24'h320411, 24'h120F00, 24'h710211, 24'h541011, 24'h940010,
    24'h052000, 24'hA52011, 24'h252011, 24'hB3FF00};
  always #2.5 ref_clk = ~ref_clk;
  terl_event_logic i_terl_event_logic (.*);
  terl_partner i_terl_partner (.*, .adc_sel(1'b1));
  function automatic logic [8:0] ad(input int c, r);
    return 9'((c / 6) * 256 + (c % 6) * 32 + r * 4);
  endfunction
  task automatic chk(input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    q = wb_dat_o;
    if (n == 40) chk(wb_ack_o, 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge ref_clk);
  endtask
  task automatic pulse(input int c, k);
    if (k < 4) capture_evt[4*c+k] <= 1'b1;
    else if (k == 4) overflow_evt[c] <= 1'b1;
    else underflow_evt[c] <= 1'b1;
    @(posedge ref_clk);
    {capture_evt, overflow_evt, underflow_evt} <= 72'h0;
    @(posedge ref_clk);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    ncyc++;
    if (ncyc == 4000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 12; i++) begin
      c = rows[i][23:20];
      k = rows[i][19:16];
      bus(1'b1, ad(c, 1), rows[i][15:8]);
      bus(1'b1, ad(c, 2), 32'h00000F00);
      pulse(c, k);
      g = k < 4 ? match_irq_request[4*c+k] : k == 4 ? overflow_irq_request[c]
        : underflow_irq_request[c];
      chk(g, rows[i][0]);
      bus(1'b0, ad(c, 0), 32'h0);
      chk(q[k], rows[i][4]);
      bus(1'b1, ad(c, 0), 32'h0);
      chk(|{match_irq_request, overflow_irq_request, underflow_irq_request,
        dma_request}, 1'b0);
    end
    bus(1'b1, ad(0, 4), 32'h00001234);
    bus(1'b1, ad(0, 2), 32'h00000003);
    bus(1'b1, ad(0, 1), 32'h00000001);
    timer_counter[15:0] <= 16'h1234;
    repeat (3) @(posedge ref_clk);
    chk(match_irq_request[0], 1'b0);
    count_tick[0] <= 1'b1;
    @(posedge ref_clk);
    count_tick[0] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({match_irq_request[0], compare_output_pin[0]}, 2'h3);
    bus(1'b1, ad(2, 1), 32'h00000010);
    pulse(2, 4);
    bus(1'b1, ad(2, 0), 32'h0);
    chk(overflow_irq_request[2], 1'b1);
    bus(1'b1, ad(7, 1), 32'h00000081);
    pulse(7, 0);
    chk(conversion_start_request, 6'h00);
    bus(1'b1, ad(1, 1), 32'h00000081);
    pulse(1, 0);
    chk(conversion_start_request, 6'h02);
    @(posedge ref_clk);
    chk(n_conv, 1);
    dma_on <= 1'b1;
    bus(1'b1, ad(9, 1), 32'h00000003);
    pulse(9, 1);
    chk({dma_request[9], match_irq_request[37]}, 2'h1);
    pulse(9, 0);
    repeat (8) @(posedge ref_clk);
    chk({dma_request[9], match_irq_request[37:36]}, 3'h2);
    bus(1'b0, 9'h0CC, 32'h0);
    chk(q, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(|{match_irq_request, overflow_irq_request, compare_output_pin}, 1'b0);
    bus(1'b0, ad(3, 5), 32'h0);
    chk(q, 32'h0000FFFF);
    print_verdict;
  end
endmodule // tb
